// ==== core/iommu_regs_params.svh ====
// Purpose: offsets, field positions, reset values and response codes
// Assumes: 32-bit AXI4-Lite register window, byte addresses
// Notes: definitions only
`ifndef IOMMU_REGS_PARAMS_SVH
`define IOMMU_REGS_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FEATURE_ID_FIVE_OFFSET 8'h14
`define IMPLEMENTATION_IDENT_OFFSET 8'h18
`define ARCHITECTURE_REVISION_OFFSET 8'h1c
`define GLOBAL_CONTROL_OFFSET 8'h20
`define CONTROL_ACKNOWLEDGE_OFFSET 8'h24

// ----------------------------------------
// control field positions
// ----------------------------------------
`define WALK_EN_BIT 10
`define VMW_LSB 6
`define VMW_MSB 8
`define ATS_CHECK_BIT 4
`define CMDQ_EN_BIT 3
`define EVENTQ_EN_BIT 2
`define PAGEQ_EN_BIT 1
`define XLATE_EN_BIT 0
`define VMW_MAX_CODE 3'h4
`define CTRL_RESET 11'h000

// ----------------------------------------
// feature word field positions
// ----------------------------------------
`define OAS_MSB 2
`define GRANULE_64K_SUPPORT_BIT 6
`define DS_BIT 7
`define WIDE_DESCRIPTOR_SUPPORT_BIT 8
`define OAS_CODE_52 3'h6
`define OAS_CODE_56 3'h7
`define ARCH_MAJOR_V3 4'h0
`define ARCH_MINOR_MAX 4'h4

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== core/iommu_regs_pkg.sv ====
// Purpose: types shared by the identification and control register bank
// Assumes: constants live in iommu_regs_params.svh
// Notes: no logic here
package iommu_regs_pkg;
    typedef logic [10:0] ctrl_word_t;

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        ctrl_word_t ctrl;
        ctrl_word_t ack;
    } bank_state_t;
endpackage

// ==== core/iommu_id_and_control_regs.sv ====
// Purpose: identification words and global control register over AXI4-Lite
// Assumes: single clock aclk, synchronous active-low aresetn, busy inputs on aclk
// Notes: acknowledge register mirrors control once each change takes effect
// Function
// - 3-bit output width code: 0-5 mean 32..48, 6 means 52, 7 means 56 bits.
// - output width 52 needs 64KB granule, small-granule large address or wide descriptors.
// - output width 56 needs wide descriptor support reported.
// - ident word: product 31:20, variant 19:16, revision 15:12, implementer 11:0.
// - implementer: continuation 11:8, zero bit 7, identity 6:0.
// - revision word: zero 31:8, major 7:4 is zero, minor 3:0 from 0 to 4.
// - bit 10 enables permission-table walks; a change completes into the acknowledge.
// - walk enable acknowledged at 1 allows fetches and suppresses walk-disabled faults.
// - walk enable drops to 0 acknowledged only after outstanding fetches finish.
// - walk enable is read-only while it differs from its acknowledge.
// - bits 8:6 vmid wildcard for invalidations; codes 1-4 ignore 1-4 low bits.
// - reserved wildcard codes behave as exact match.
// - wildcard leaves ordinary translation lookups unchanged.
// - bit 4 selects ats pass-through or check against stream entry.
// - bit 3 enables command queue processing.
// - bit 2 gates event queue writes.
// - bit 1 gates page-request queue writes when implemented, else reads zero.
// - bit 0 is global translation enable; clear means bypass.
// - every implemented control field resets to zero.
// - acknowledge mirrors each control field once its change takes effect.
// - no command fetch while command queue enable is zero.
`timescale 1ns/10ps
`include "iommu_regs_params.svh"

module iommu_id_and_control_regs #(
    parameter logic [2:0] OUT_ADDR_CODE = 3'h5,
    parameter logic GRANULE_64K_SUPPORT = 1'b1,
    parameter logic SMALL_GRAN_LARGE_ADDR = 1'b0,
    parameter logic WIDE_DESC = 1'b0,
    // identity values below are arbitrary
    parameter logic [11:0] PRODUCT_CODE = 12'h123,
    parameter logic [3:0] VARIANT = 4'h0,
    parameter logic [3:0] REVISION = 4'h0,
    parameter logic [3:0] JEP_CONTINUATION = 4'h0,
    parameter logic [6:0] JEP_IDENTITY = 7'h55,
    parameter logic [3:0] ARCH_MINOR = 4'h4,
    parameter logic WALK_IMPL = 1'b1,
    parameter logic VMW_IMPL = 1'b1,
    parameter logic ATS_IMPL = 1'b1,
    parameter logic PAGEQ_IMPL = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic perm_fetch_busy,
    input wire logic cmd_fetch_busy,
    input wire logic event_write_busy,
    input wire logic page_req_write_busy,
    output logic perm_fetch_enable,
    output logic walk_disabled_fault_off,
    output logic [2:0] vmid_inval_ignore_bits,
    output logic ats_check_mode,
    output logic cmd_queue_enable,
    output logic event_queue_enable,
    output logic page_req_queue_enable,
    output logic translate_enable
);

    // ----------------------------------------
    // constant words
    // ----------------------------------------
    logic [31:0] feature_id_five;
    logic [31:0] implementation_ident;
    logic [31:0] architecture_revision;
    iommu_regs_pkg::ctrl_word_t impl_mask;

    always_comb begin
        feature_id_five = 32'h0;
        feature_id_five[`OAS_MSB:0] = OUT_ADDR_CODE;
        feature_id_five[`GRANULE_64K_SUPPORT_BIT] = GRANULE_64K_SUPPORT;
        feature_id_five[`DS_BIT] = SMALL_GRAN_LARGE_ADDR;
        feature_id_five[`WIDE_DESCRIPTOR_SUPPORT_BIT] = WIDE_DESC;
    end

    // implementer code keeps bit 7 at zero
    assign implementation_ident = {PRODUCT_CODE, VARIANT, REVISION,
        JEP_CONTINUATION, 1'b0, JEP_IDENTITY};
    assign architecture_revision = {24'h0, `ARCH_MAJOR_V3, ARCH_MINOR};

    always_comb begin
        impl_mask = 11'h0;
        impl_mask[`WALK_EN_BIT] = WALK_IMPL;
        impl_mask[`VMW_MSB:`VMW_LSB] = {3{VMW_IMPL}};
        impl_mask[`ATS_CHECK_BIT] = ATS_IMPL;
        impl_mask[`CMDQ_EN_BIT] = 1'b1;
        impl_mask[`EVENTQ_EN_BIT] = 1'b1;
        impl_mask[`PAGEQ_EN_BIT] = PAGEQ_IMPL;
        impl_mask[`XLATE_EN_BIT] = 1'b1;
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    iommu_regs_pkg::bank_state_t st;
    iommu_regs_pkg::bank_state_t next_st;
    iommu_regs_pkg::ctrl_word_t drain_busy;
    iommu_regs_pkg::ctrl_word_t next_ack;
    logic do_write;
    logic do_read;
    logic [31:0] wr_mask;
    logic [31:0] merged;
    logic [31:0] read_word;
    logic read_hit;

    always_comb begin
        drain_busy = 11'h0;
        drain_busy[`WALK_EN_BIT] = perm_fetch_busy;
        drain_busy[`CMDQ_EN_BIT] = cmd_fetch_busy;
        drain_busy[`EVENTQ_EN_BIT] = event_write_busy;
        drain_busy[`PAGEQ_EN_BIT] = page_req_write_busy;
    end

    // ----------------------------------------
    // acknowledge update per field
    // ----------------------------------------
    // a field falling to 0 is held until its engine drains, so the
    // acknowledge never claims a stop that has not happened yet
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_ack
            always_comb begin
                if (!st.ctrl[gi] && st.ack[gi] && drain_busy[gi]) begin
                    next_ack[gi] = st.ack[gi];
                end else begin
                    next_ack[gi] = st.ctrl[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // bus handshakes
    // ----------------------------------------
    // readies drop while frozen; bready and rready must wait for ce as well
    assign s_axi_awready = ce && !st.aw_held && !st.bvalid;
    assign s_axi_wready = ce && !st.w_held && !st.bvalid;
    assign s_axi_arready = ce && !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign do_write = st.aw_held && st.w_held && !st.bvalid;
    assign do_read = s_axi_arvalid && !st.rvalid;

    always_comb begin
        wr_mask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}},
            {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
        merged = ({21'h0, st.ctrl} & ~wr_mask) | (st.w_data & wr_mask);
    end

    always_comb begin
        read_hit = 1'b1;
        unique case (s_axi_araddr)
            `FEATURE_ID_FIVE_OFFSET: read_word = feature_id_five;
            `IMPLEMENTATION_IDENT_OFFSET: read_word = implementation_ident;
            `ARCHITECTURE_REVISION_OFFSET: read_word = architecture_revision;
            `GLOBAL_CONTROL_OFFSET: read_word = {21'h0, st.ctrl};
            `CONTROL_ACKNOWLEDGE_OFFSET: read_word = {21'h0, st.ack};
            default: begin
                read_word = 32'h0;
                read_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = next_ack & impl_mask;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `RESP_OKAY;
            unique case (st.aw_addr)
                `GLOBAL_CONTROL_OFFSET: begin
                    next_st.ctrl = merged[10:0] & impl_mask;
                    if (st.ctrl[`WALK_EN_BIT] != st.ack[`WALK_EN_BIT]) begin
                        next_st.ctrl[`WALK_EN_BIT] = st.ctrl[`WALK_EN_BIT];
                    end
                end
                // identification words and acknowledge are read-only
                `FEATURE_ID_FIVE_OFFSET, `IMPLEMENTATION_IDENT_OFFSET,
                `ARCHITECTURE_REVISION_OFFSET, `CONTROL_ACKNOWLEDGE_OFFSET: begin
                    next_st.bresp = `RESP_OKAY;
                end
                default: next_st.bresp = `RESP_DECERR;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (do_read) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word;
            next_st.rresp = read_hit ? `RESP_OKAY : `RESP_DECERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctrl <= `CTRL_RESET;
            st.ack <= `CTRL_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // effective controls
    // ----------------------------------------
    // new fetches stop on the write itself; acknowledge follows the drain
    assign perm_fetch_enable = st.ctrl[`WALK_EN_BIT] & st.ack[`WALK_EN_BIT];
    assign walk_disabled_fault_off = st.ack[`WALK_EN_BIT];
    assign cmd_queue_enable = st.ctrl[`CMDQ_EN_BIT] & st.ack[`CMDQ_EN_BIT];
    assign event_queue_enable = st.ctrl[`EVENTQ_EN_BIT] & st.ack[`EVENTQ_EN_BIT];
    // page-request writes also depend on translation being on
    assign page_req_queue_enable = st.ctrl[`PAGEQ_EN_BIT] & st.ack[`PAGEQ_EN_BIT]
        & st.ack[`XLATE_EN_BIT];
    assign translate_enable = st.ack[`XLATE_EN_BIT];
    assign ats_check_mode = st.ack[`ATS_CHECK_BIT];

    // invalidation only; lookups never see this output
    always_comb begin
        if (st.ack[`VMW_MSB:`VMW_LSB] <= `VMW_MAX_CODE) begin
            vmid_inval_ignore_bits = st.ack[`VMW_MSB:`VMW_LSB];
        end else begin
            vmid_inval_ignore_bits = 3'h0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence ctrl_write_s;
        ce && do_write && st.aw_addr == `GLOBAL_CONTROL_OFFSET;
    endsequence

    chk_oas_52_features: assert property (
        feature_id_five[`OAS_MSB:0] == `OAS_CODE_52 |->
        (GRANULE_64K_SUPPORT || SMALL_GRAN_LARGE_ADDR || WIDE_DESC))
        else $error("52-bit output width without a supporting feature");
    chk_oas_56_wide: assert property (
        feature_id_five[`OAS_MSB:0] == `OAS_CODE_56 |-> feature_id_five[`WIDE_DESCRIPTOR_SUPPORT_BIT])
        else $error("56-bit output width without wide descriptors");
    chk_ident_zero_bit: assert property (
        implementation_ident[7] == 1'b0 && implementation_ident[31:20] == PRODUCT_CODE)
        else $error("ident word layout wrong");
    chk_revision_word: assert property (
        architecture_revision[31:4] == 28'h0 && architecture_revision[3:0] <= `ARCH_MINOR_MAX)
        else $error("revision word out of range");
    chk_walk_locked: assert property (
        ctrl_write_s and (st.ctrl[`WALK_EN_BIT] != st.ack[`WALK_EN_BIT])
        |=> $stable(st.ctrl[`WALK_EN_BIT]))
        else $error("walk enable changed while in transition");
    chk_ack_follows: assert property (
        ce && st.ctrl[`XLATE_EN_BIT] != st.ack[`XLATE_EN_BIT]
        |=> st.ack[`XLATE_EN_BIT] == $past(st.ctrl[`XLATE_EN_BIT]))
        else $error("acknowledge did not follow control");
    chk_walk_drain: assert property (
        st.ack[`WALK_EN_BIT] && !st.ctrl[`WALK_EN_BIT] && perm_fetch_busy
        |=> st.ack[`WALK_EN_BIT] || !$past(ce))
        else $error("walk disable acknowledged with fetches pending");
    chk_cmd_no_fetch: assert property (
        !st.ctrl[`CMDQ_EN_BIT] |-> !cmd_queue_enable)
        else $error("command fetch allowed while disabled");
    chk_vmw_reserved: assert property (
        st.ack[`VMW_MSB:`VMW_LSB] > `VMW_MAX_CODE |-> vmid_inval_ignore_bits == 3'h0)
        else $error("reserved wildcard code not exact match");
    chk_reset_zero: assert property (
        $rose(aresetn) |-> st.ctrl == 11'h0 && st.ack == 11'h0)
        else $error("control not zero after reset");

    // ----------------------------------------
    // bus, update and freeze checks
    // ----------------------------------------
    sequence write_taken_s;
        ce && do_write;
    endsequence

    sequence read_taken_s;
        ce && do_read;
    endsequence

    // a frozen block must neither move nor offer a handshake it cannot take
    chk_freeze_state: assert property (
        !ce |=> st == $past(st))
        else $error("state moved while clock enable low");
    chk_freeze_ready: assert property (
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("handshake offered while clock enable low");
    chk_write_answer: assert property (
        write_taken_s |=> st.bvalid && !st.aw_held && !st.w_held)
        else $error("write taken without a response");
    chk_read_answer: assert property (
        read_taken_s |=> st.rvalid)
        else $error("read taken without a response");
    chk_bvalid_stands: assert property (
        st.bvalid && !(ce && s_axi_bready) |=> st.bvalid && $stable(st.bresp))
        else $error("write response dropped before it was taken");
    chk_rvalid_stands: assert property (
        st.rvalid && !(ce && s_axi_rready) |=> st.rvalid && $stable(st.rdata))
        else $error("read data changed before it was taken");
    chk_nonctrl_write: assert property (
        write_taken_s ##0 (st.aw_addr != `GLOBAL_CONTROL_OFFSET) |=> $stable(st.ctrl))
        else $error("write outside control changed the control word");
    chk_ident_read: assert property (
        read_taken_s ##0 (s_axi_araddr == `IMPLEMENTATION_IDENT_OFFSET)
        |=> st.rdata == implementation_ident && st.rresp == `RESP_OKAY)
        else $error("ident read returned the wrong word");
    chk_feature_read: assert property (
        read_taken_s ##0 (s_axi_araddr == `FEATURE_ID_FIVE_OFFSET)
        |=> st.rdata[`OAS_MSB:0] == OUT_ADDR_CODE)
        else $error("feature read returned the wrong width code");
    chk_revision_read: assert property (
        read_taken_s ##0 (s_axi_araddr == `ARCHITECTURE_REVISION_OFFSET)
        |=> st.rdata == {24'h0, `ARCH_MAJOR_V3, ARCH_MINOR})
        else $error("revision read returned the wrong word");
    chk_walk_lands: assert property (
        ctrl_write_s ##0 (st.w_strb[1] && st.ctrl[`WALK_EN_BIT] == st.ack[`WALK_EN_BIT])
        |=> st.ctrl[`WALK_EN_BIT] == ($past(st.w_data[`WALK_EN_BIT]) && WALK_IMPL))
        else $error("walk enable write did not land");
    chk_walk_ack_rise: assert property (
        ce && st.ctrl[`WALK_EN_BIT] && !st.ack[`WALK_EN_BIT] |=> walk_disabled_fault_off)
        else $error("walk enable rise not acknowledged");
    chk_cmd_drain: assert property (
        st.ack[`CMDQ_EN_BIT] && !st.ctrl[`CMDQ_EN_BIT] && cmd_fetch_busy
        |=> st.ack[`CMDQ_EN_BIT])
        else $error("command queue stop acknowledged with fetches pending");
    chk_event_drain: assert property (
        st.ack[`EVENTQ_EN_BIT] && !st.ctrl[`EVENTQ_EN_BIT] && event_write_busy
        |=> st.ack[`EVENTQ_EN_BIT])
        else $error("event queue stop acknowledged with writes pending");
    chk_pageq_drain: assert property (
        st.ack[`PAGEQ_EN_BIT] && !st.ctrl[`PAGEQ_EN_BIT] && page_req_write_busy
        |=> st.ack[`PAGEQ_EN_BIT])
        else $error("page-request stop acknowledged with writes pending");
    chk_bypass_off: assert property (
        !st.ack[`XLATE_EN_BIT] |-> !translate_enable && !page_req_queue_enable)
        else $error("translation active while disabled");
    chk_ats_follows: assert property (
        ce && st.ctrl[`ATS_CHECK_BIT] != st.ack[`ATS_CHECK_BIT]
        |=> ats_check_mode == $past(st.ctrl[`ATS_CHECK_BIT]))
        else $error("ats check mode did not follow control");

endmodule

// ==== test/iommu_id_and_control_regs_bench.sv ====
// Purpose: self-checking bench for the identification and control register bank
// Assumes: ce low only while the bus is idle; bready and rready raised after a random wait
// Notes: bus answers are checked by a monitor against notes queued by the driver
`timescale 1ns/10ps
`include "iommu_regs_params.svh"

module iommu_id_and_control_regs_bench;
    // identity values are arbitrary
    localparam logic [31:0] FEAT_EXP = 32'h0000_0086;
    localparam logic [31:0] IDENT_EXP = 32'h1233_1055;
    localparam logic [31:0] REV_EXP = 32'h0000_0004;
    logic aclk, aresetn, ce;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb, busy;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] obs;
    logic [10:0] ctrl_m;
    logic [34:0] note_q[$];
    logic [7:0] ro_addr[4] = '{8'h14, 8'h18, 8'h1c, 8'h24};
    logic [31:0] ro_exp[4] = '{FEAT_EXP, IDENT_EXP, REV_EXP, 32'h0};
    int errors = 0;
    int cmp_count = 0;
    logic [33:0] r_word;
    assign r_word = {s_axi_rresp, s_axi_rdata};

    iommu_id_and_control_regs #(.OUT_ADDR_CODE(3'h6), .GRANULE_64K_SUPPORT(1'b0),
        .SMALL_GRAN_LARGE_ADDR(1'b1), .VARIANT(4'h3), .REVISION(4'h1)
    ) i_iommu_id_and_control_regs (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .perm_fetch_busy(busy[3]), .cmd_fetch_busy(busy[2]),
        .event_write_busy(busy[1]), .page_req_write_busy(busy[0]),
        .perm_fetch_enable(obs[9]), .walk_disabled_fault_off(obs[8]),
        .vmid_inval_ignore_bits(obs[7:5]), .ats_check_mode(obs[4]),
        .cmd_queue_enable(obs[3]), .event_queue_enable(obs[2]),
        .page_req_queue_enable(obs[1]), .translate_enable(obs[0]));

    // ----------------------------------------
    // clock, reporting, helpers
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // steady state: control and acknowledge agree
    function automatic logic [9:0] outs(input logic [10:0] c);
        return {c[10], c[10], (c[8:6] <= 3'h4) ? c[8:6] : 3'h0, c[4:2], c[1] & c[0], c[0]};
    endfunction

    // ----------------------------------------
    // bus master tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        seed = xs(seed);
        note_q.push_back({1'b0, r, 32'h0});
        s_axi_bready <= 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (seed[1:0]) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic care, input logic [33:0] e);
        seed = xs(seed);
        note_q.push_back({care, e});
        s_axi_rready <= 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat (seed[1:0]) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    endtask

    // control write while no field is mid-update, then read both copies back
    task automatic ctl_step(input logic [31:0] d, input logic [3:0] s);
        ctrl_m = {s[1] ? d[10:8] : ctrl_m[10:8], s[0] ? d[7:0] : ctrl_m[7:0]} & 11'h5df;
        wr(8'h20, d, s, 2'h0);
        repeat (3) @(posedge aclk);
        rd(8'h20, 1'b1, {23'h0, ctrl_m});
        rd(8'h24, 1'b1, {23'h0, ctrl_m});
        check(34'(obs), 34'(outs(ctrl_m)));
    endtask

    // ----------------------------------------
    // answer monitor
    // ----------------------------------------
    always @(posedge aclk) begin
        logic [34:0] note;
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            note = note_q.pop_front();
            check(34'(s_axi_bresp), 34'(note[33:32]));
        end
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            note = note_q.pop_front();
            if (note[34]) check(r_word, note[33:0]);
            else check(34'(s_axi_rresp), 34'(note[33:32]));
        end
    end

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        close_out();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        busy = 4'h0;
        s_axi_awaddr = 8'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 8'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        seed = 32'h4f07;
        ctrl_m = 11'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(34'(obs), 34'h0);
        rd(8'h20, 1'b1, 34'h0);
        for (int k = 0; k < 4; k++) begin
            rd(ro_addr[k], 1'b1, {2'h0, ro_exp[k]});
            wr(ro_addr[k], 32'hffff_ffff, 4'hf, 2'h0);
            rd(ro_addr[k], 1'b1, {2'h0, ro_exp[k]});
        end
        $display("test reset and identification done");
        wr(8'h28, 32'hffff_ffff, 4'hf, 2'h3);
        rd(8'h28, 1'b0, {2'h3, 32'h0});
        rd(8'h20, 1'b1, 34'h0);
        $display("test unmapped done");
        for (int k = 0; k < 8; k++) ctl_step(32'(k) << 6, 4'hf);
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            ctl_step(seed, seed[27:24]);
        end
        $display("test control fields done");
        ctl_step(32'h0, 4'hf);
        ctl_step(32'h40e, 4'hf);
        busy <= 4'hf;
        wr(8'h20, 32'h0, 4'hf, 2'h0);
        repeat (4) @(posedge aclk);
        rd(8'h24, 1'b1, 34'h40e);
        check(34'(obs), 34'h100);
        wr(8'h20, 32'h400, 4'hf, 2'h0);
        rd(8'h20, 1'b1, 34'h0);
        ce <= 1'b0;
        busy <= 4'h0;
        repeat (4) @(posedge aclk);
        check(34'(obs), 34'h100);
        ce <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(8'h24, 1'b1, 34'h0);
        check(34'(obs), 34'h0);
        $display("test drain and lockout done");
        close_out();
    end
endmodule
